//--- hdl/cyc_timer.sv
// Loadable down-counter that pulses done when the count expires
`timescale 1ns/100ps
module cyc_timer (
   input wire logic clock_in,
   input wire logic rst_n_in,
   cyc_timer_if.timer tmr
);
   typedef struct packed {
      logic [31:0] cnt;
      logic run;
      logic done;
   } tstate_s;
   tstate_s s_q, s_d;
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (tmr.start) begin
         s_d.cnt = tmr.count;
         s_d.run = 1'b1;
      end else if (s_q.run) begin
         if (s_q.cnt <= 32'h1) begin
            s_d.run = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 32'h1;
         end
      end
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tmr.done = s_q.done;
endmodule : cyc_timer

//--- hdl/cyc_timer_if.sv
// Handshake between the sequencer and its cycle timer
`timescale 1ns/100ps
interface cyc_timer_if;
   logic start;
   logic [31:0] count;
   logic done;
   modport ctrl (output start, output count, input done);
   modport timer (input start, input count, output done);
endinterface : cyc_timer_if

//--- hdl/otp_prog_cfg.svh
// Timing and algorithm constants for the one-time-programmable byte sequencer
`ifndef OTP_PROG_CFG_SVH
`define OTP_PROG_CFG_SVH
`define CLK_PERIOD_NS 8
`define PULSE_NOM_US 100
`define PULSE_CYC ((`PULSE_NOM_US * 1000) / `CLK_PERIOD_NS)
`define SETUP_US 2
`define SETUP_CYC ((`SETUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_VALID_US 1
`define DATA_VALID_CYC \
   ((`DATA_VALID_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_RETRY 10
`define ADDR_W 16
`define DATA_W 8
`endif

//--- hdl/otp_prog_pkg.sv
// Types shared by the sequencer modules
package otp_prog_pkg;
   typedef enum logic [2:0] {
      SUP_OFF, SUP_READ, SUP_PROG
   } supply_e;
   typedef enum logic [3:0] {
      ST_IDLE, ST_RAMP, ST_PULSE, ST_RECOVER, ST_VERIFY, ST_RETRY,
      ST_LOWER, ST_READBACK, ST_ID, ST_DONE
   } phase_e;
endpackage : otp_prog_pkg

//--- hdl/otp_prog_seq.sv
// Programmer sequencer that writes, verifies and identifies an OTP memory
// Summary of operation
// - Each write pulse holds chip enable low for 100 us, within 95 to 105.
// - Address starts at zero and supplies are raised before any pulse.
// - The first pass gives every address one pulse with no check.
// - Then each address is verified and re-pulsed up to ten times.
// - A byte still wrong after ten retries stops the run as failed.
// - A verified byte moves on to the next address until all are checked.
// - Supplies are lowered, then every byte is read and compared.
`timescale 1ns/100ps
`include "otp_prog_cfg.svh"
module otp_prog_seq import otp_prog_pkg::*; #(
   parameter int ADDR_W = `ADDR_W,
   parameter int MAX_RETRY = `MAX_RETRY,
   parameter int PULSE_CYC = `PULSE_CYC
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic start_prog_in,
   input wire logic start_id_in,
   input wire logic [ADDR_W-1:0] last_addr_in,
   input wire logic [7:0] src_data_in,
   input wire logic [7:0] byte_output_lines_in,
   output logic [ADDR_W-1:0] src_addr_out,
   output logic [ADDR_W-1:0] dev_addr_out,
   output logic [7:0] dev_data_out,
   output logic dev_data_oe_out,
   output logic ce_n_out,
   output logic oe_n_out,
   output supply_e supply_out,
   output logic id_sense_voltage_out,
   output logic [7:0] mfr_code_out,
   output logic [7:0] dev_code_out,
   output logic busy_out,
   output logic pass_out,
   output logic fail_out
);
   localparam int SETUP_CYC = `SETUP_CYC;
   localparam int DV_CYC = `DATA_VALID_CYC;
   // Retry count is four bits wide and the address at most sixteen
   if (ADDR_W < 1 || ADDR_W > 16 || MAX_RETRY < 1 || MAX_RETRY > 15
       || PULSE_CYC < 2) begin : g_bad_params
      $error("otp_prog_seq: unsupported parameter values");
   end
   typedef struct packed {
      phase_e ph;
      logic pass2;
      logic [ADDR_W-1:0] addr;
      logic [3:0] retry;
      logic ce_n;
      logic oe_n;
      supply_e sup;
      logic id_volt;
      logic doe;
      logic [7:0] dat;
      logic [7:0] mfr;
      logic [7:0] dev;
      logic busy;
      logic pass;
      logic fail;
      logic tstart;
      logic [31:0] tcnt;
      logic id_bit;
   } seq_s;
   seq_s s_q, s_d;
   cyc_timer_if tif ();
   cyc_timer u_timer (.clock_in(clock_in), .rst_n_in(rst_n_in), .tmr(tif));
   assign tif.start = s_q.tstart;
   assign tif.count = s_q.tcnt;
   wire logic last = (s_q.addr == last_addr_in);
   always_comb begin
      s_d = s_q;
      s_d.tstart = 1'b0;
      unique case (s_q.ph)
         ST_IDLE: begin
            if (start_prog_in) begin
               s_d.addr = '0;
               s_d.sup = SUP_PROG;
               s_d.oe_n = 1'b1;
               s_d.pass2 = 1'b0;
               s_d.retry = 4'h0;
               s_d.busy = 1'b1;
               s_d.pass = 1'b0;
               s_d.fail = 1'b0;
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(SETUP_CYC);
               s_d.ph = ST_RAMP;
            end else if (start_id_in) begin
               s_d.id_volt = 1'b1;
               s_d.sup = SUP_READ;
               s_d.addr = '0;
               s_d.id_bit = 1'b0;
               s_d.ce_n = 1'b0;
               s_d.oe_n = 1'b0;
               s_d.busy = 1'b1;
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(SETUP_CYC);
               s_d.ph = ST_ID;
            end
         end
         ST_RAMP: begin
            s_d.dat = src_data_in;
            s_d.doe = 1'b1;
            if (tif.done) begin
               s_d.ce_n = 1'b0;
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(PULSE_CYC);
               s_d.ph = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (tif.done) begin
               s_d.ce_n = 1'b1;
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(SETUP_CYC);
               s_d.ph = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (tif.done) begin
               if (!s_q.pass2 && !last) begin
                  s_d.addr = s_q.addr + 1'b1;
                  s_d.tstart = 1'b1;
                  s_d.tcnt = 32'(SETUP_CYC);
                  s_d.ph = ST_RAMP;
               end else begin
                  if (!s_q.pass2) begin
                     s_d.addr = '0;
                     s_d.retry = 4'h0;
                  end
                  s_d.pass2 = 1'b1;
                  s_d.doe = 1'b0;
                  s_d.ce_n = 1'b0;
                  s_d.oe_n = 1'b0;
                  s_d.tstart = 1'b1;
                  s_d.tcnt = 32'(SETUP_CYC + DV_CYC);
                  s_d.ph = ST_VERIFY;
               end
            end
         end
         ST_VERIFY: begin
            if (tif.done) begin
               s_d.ce_n = 1'b1;
               s_d.oe_n = 1'b1;
               if (byte_output_lines_in == src_data_in) begin
                  if (last) begin
                     s_d.sup = SUP_READ;
                     s_d.addr = '0;
                     s_d.tstart = 1'b1;
                     s_d.tcnt = 32'(SETUP_CYC);
                     s_d.ph = ST_LOWER;
                  end else begin
                     s_d.addr = s_q.addr + 1'b1;
                     s_d.retry = 4'h0;
                     s_d.tstart = 1'b1;
                     s_d.tcnt = 32'(SETUP_CYC);
                     s_d.ph = ST_RETRY;
                  end
               end else if (s_q.retry == 4'(MAX_RETRY)) begin
                  s_d.fail = 1'b1;
                  s_d.ph = ST_DONE;
               end else begin
                  s_d.retry = s_q.retry + 4'h1;
                  s_d.tstart = 1'b1;
                  s_d.tcnt = 32'(SETUP_CYC);
                  s_d.ph = ST_RAMP;
               end
            end
         end
         ST_RETRY: begin
            if (tif.done) begin
               s_d.ce_n = 1'b0;
               s_d.oe_n = 1'b0;
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(SETUP_CYC + DV_CYC);
               s_d.ph = ST_VERIFY;
            end
         end
         ST_LOWER: begin
            s_d.ce_n = 1'b0;
            s_d.oe_n = 1'b0;
            if (tif.done) begin
               s_d.tstart = 1'b1;
               s_d.tcnt = 32'(DV_CYC);
               s_d.ph = ST_READBACK;
            end
         end
         ST_READBACK: begin
            if (tif.done) begin
               if (byte_output_lines_in != src_data_in) begin
                  s_d.fail = 1'b1;
                  s_d.ph = ST_DONE;
               end else if (last) begin
                  s_d.pass = 1'b1;
                  s_d.ph = ST_DONE;
               end else begin
                  s_d.addr = s_q.addr + 1'b1;
                  s_d.tstart = 1'b1;
                  s_d.tcnt = 32'(DV_CYC);
               end
            end
         end
         ST_ID: begin
            if (tif.done) begin
               if (!s_q.id_bit) begin
                  s_d.mfr = byte_output_lines_in;
                  s_d.id_bit = 1'b1;
                  s_d.addr = ADDR_W'(1);
                  s_d.tstart = 1'b1;
                  s_d.tcnt = 32'(SETUP_CYC);
               end else begin
                  s_d.dev = byte_output_lines_in;
                  s_d.id_volt = 1'b0;
                  s_d.ph = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.doe = 1'b0;
            s_d.sup = SUP_OFF;
            s_d.busy = 1'b0;
            s_d.ph = ST_IDLE;
         end
      endcase
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q <= '{ph: ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, sup: SUP_OFF,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end
   assign src_addr_out = s_q.addr;
   assign dev_addr_out = s_q.addr;
   assign dev_data_out = s_q.dat;
   assign dev_data_oe_out = s_q.doe;
   assign ce_n_out = s_q.ce_n;
   assign oe_n_out = s_q.oe_n;
   assign supply_out = s_q.sup;
   assign id_sense_voltage_out = s_q.id_volt;
   assign mfr_code_out = s_q.mfr;
   assign dev_code_out = s_q.dev;
   assign busy_out = s_q.busy;
   assign pass_out = s_q.pass;
   assign fail_out = s_q.fail;

   // Pulse length counted on the chip enable output itself
   logic [31:0] low_cnt;
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_cnt <= '0;
      end else if (ce_n_out || !oe_n_out) begin
         low_cnt <= '0;
      end else begin
         low_cnt <= low_cnt + 32'h1;
      end
   end
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   a_pulse_width_max: assert property ((!ce_n_out && oe_n_out) |->
      low_cnt < 32'(PULSE_CYC) + 2) else $error("program pulse too long");
   a_pulse_width_min: assert property ($rose(ce_n_out) &&
      $past(oe_n_out) && busy_out |-> $past(low_cnt) >= 32'(PULSE_CYC) - 1)
      else $error("program pulse too short");
   a_supply_before: assert property ((!ce_n_out && oe_n_out) |->
      supply_out == SUP_PROG) else $error("pulse without raised supply");
   a_first_pass: assert property (!s_q.pass2 &&
      s_q.ph == ST_RECOVER |-> s_q.retry == 4'h0 && oe_n_out)
      else $error("check during first pass");
   a_retry_bound: assert property (s_q.retry <= 4'(MAX_RETRY))
      else $error("retry count exceeded");
   a_fail_stop: assert property ($rose(fail_out) |=>
      !busy_out && supply_out == SUP_OFF) else $error("failure did not stop");
   a_advance_ok: assert property (s_q.ph == ST_VERIFY && tif.done &&
      !last && byte_output_lines_in == src_data_in |=>
      src_addr_out == $past(src_addr_out) + 1'b1) else $error("no advance");
   a_lower_read: assert property (s_q.ph == ST_READBACK |->
      supply_out == SUP_READ && !dev_data_oe_out)
      else $error("readback at program supply");
   a_id_select: assert property (s_q.ph == ST_ID |->
      id_sense_voltage_out && dev_addr_out[0] == s_q.id_bit)
      else $error("id select wrong");
   a_verify_read: assert property (s_q.ph == ST_VERIFY |->
      !dev_data_oe_out && !ce_n_out && !oe_n_out)
      else $error("verify not a read");
   c_pass: cover property ($rose(pass_out));
   c_fail: cover property ($rose(fail_out));
   c_retry: cover property (s_q.retry == 4'h2);
   c_id: cover property ($fell(id_sense_voltage_out));
endmodule : otp_prog_seq

//--- verif/otp_dev_model.sv
// Behavioural model of the one-time-programmable byte memory
`timescale 1ns/100ps
module otp_dev_model import otp_prog_pkg::*; #(
   parameter real PW_NS = 800.0,
   parameter logic [7:0] MFR_CODE = 8'hA5, // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h5A // Arbitrary value
) (
   input wire logic ce_n_in,
   input wire logic oe_n_in,
   input wire supply_e supply_in,
   input wire logic id_volt_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] data_in,
   input wire logic data_oe_in,
   input wire logic wipe_in,
   input wire logic [15:0] need_in,
   output logic [7:0] byte_out,
   output logic [15:0] pulses_out,
   output logic [3:0] rd_seen_out,
   output int viol_out
);
   logic [7:0] mem [0:3];
   logic [3:0] pcnt [0:3];
   logic [7:0] val;
   logic [7:0] last_q = 8'h00;
   logic first_q;
   realtime t_fall;
   wire logic drive = !ce_n_in && !oe_n_in;
   wire logic prog = (supply_in === SUP_PROG) && data_oe_in;
   assign val = id_volt_in ? (addr_in[0] ? DEV_CODE : MFR_CODE)
                       : mem[addr_in[1:0]];
   // No pull on the data lines: a floating bus shows the inverse value
   assign byte_out = drive ? val : ~last_q;
   assign pulses_out = {pcnt[3], pcnt[2], pcnt[1], pcnt[0]};
   always @(negedge drive) last_q = val;
   always @(posedge wipe_in) begin
      for (int i = 0; i < 4; i++) begin
         mem[i] = 8'hFF;
         pcnt[i] = 4'h0;
      end
      rd_seen_out = 4'h0;
      viol_out = 0;
      first_q = 1'b0;
   end
   always @(negedge ce_n_in) begin
      t_fall = $realtime;
      if (data_oe_in && supply_in !== SUP_PROG) viol_out++;
      if (prog) begin
         if (!first_q && addr_in !== 16'h0000) viol_out++;
         first_q = 1'b1;
      end
   end
   // A cell only takes its byte after the stubborn count is exceeded
   always @(posedge ce_n_in) begin
      if (prog) begin
         if ($realtime - t_fall < PW_NS * 0.95 ||
             $realtime - t_fall > PW_NS * 1.05) viol_out++;
         pcnt[addr_in[1:0]]++;
         if (pcnt[addr_in[1:0]] > need_in[addr_in[1:0]*4 +: 4])
            mem[addr_in[1:0]] &= data_in;
      end
   end
   always @* begin
      if (drive && supply_in === SUP_READ && !id_volt_in)
         rd_seen_out[addr_in[1:0]] = 1'b1;
   end
endmodule : otp_dev_model

//--- verif/tb_top.sv
// Self-checking bench for the OTP program and identify sequencer
`timescale 1ns/100ps
module tb_top import otp_prog_pkg::*;;
   localparam int PCYC = 100;
   localparam int LIMIT = 80000;
   localparam logic [7:0] MFR = 8'hA5; // Arbitrary value
   localparam logic [7:0] DEVC = 8'h5A; // Arbitrary value
   typedef struct packed {
      logic [15:0] last;
      logic [15:0] need;
      logic ok;
      logic [15:0] pulses;
      logic [3:0] rd;
   } row_s;
   // Per-address pulses a cell needs beyond the first, and what follows
   row_s rows [0:4] = '{
      '{16'h0003, 16'h0000, 1'b1, 16'h1111, 4'hF},
      '{16'h0003, 16'h0300, 1'b1, 16'h1411, 4'hF},
      '{16'h0003, 16'h00A0, 1'b1, 16'h11B1, 4'hF},
      '{16'h0003, 16'h00B0, 1'b0, 16'h11B1, 4'h0},
      '{16'h0000, 16'h0000, 1'b1, 16'h0001, 4'h1}};
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_prog = 1'b0;
   logic start_id = 1'b0;
   logic wipe = 1'b0;
   logic [15:0] last_addr = 16'h0000;
   logic [15:0] need = 16'h0000;
   logic [7:0] src_mem [0:3] = '{8'h12, 8'h34, 8'h56, 8'h78};
   logic [15:0] src_addr, dev_addr, pulses;
   logic [7:0] dev_data, dev_byte, mfr_code, dev_code;
   logic data_oe, ce_n, oe_n, id_volt, busy, pass, fail;
   logic [3:0] rd_seen;
   supply_e supply;
   int viol;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   otp_prog_seq #(.PULSE_CYC(PCYC)) uut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .start_prog_in(start_prog),
      .start_id_in(start_id), .last_addr_in(last_addr),
      .src_data_in(src_mem[src_addr[1:0]]), .byte_output_lines_in(dev_byte),
      .src_addr_out(src_addr), .dev_addr_out(dev_addr),
      .dev_data_out(dev_data), .dev_data_oe_out(data_oe), .ce_n_out(ce_n),
      .oe_n_out(oe_n), .supply_out(supply), .id_sense_voltage_out(id_volt),
      .mfr_code_out(mfr_code), .dev_code_out(dev_code), .busy_out(busy),
      .pass_out(pass), .fail_out(fail));
   otp_dev_model #(.PW_NS(PCYC * 8.0), .MFR_CODE(MFR), .DEV_CODE(DEVC)) dev (
      .ce_n_in(ce_n), .oe_n_in(oe_n), .supply_in(supply),
      .id_volt_in(id_volt),
      .addr_in(dev_addr), .data_in(dev_data), .data_oe_in(data_oe),
      .wipe_in(wipe), .need_in(need), .byte_out(dev_byte),
      .pulses_out(pulses), .rd_seen_out(rd_seen), .viol_out(viol));

   initial forever #4 clock_in = ~clock_in;

   task automatic summarize;
      if (mismatches == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize

   always @(posedge clock_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         summarize();
      end
   end

   task automatic check(input string name, input logic [31:0] exp,
                        input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   // Fresh blank part each run, so earlier runs leave no programmed cells
   task automatic kick(input logic [15:0] nd, input logic [15:0] la);
      @(posedge clock_in);
      wipe <= 1'b1;
      need <= nd;
      last_addr <= la;
      @(posedge clock_in);
      wipe <= 1'b0;
      start_prog <= 1'b1;
      @(posedge clock_in);
      start_prog <= 1'b0;
   endtask : kick

   task automatic finish;
      repeat (2) @(posedge clock_in);
      #1;
      check("busy", 1, busy);
      while (busy === 1'b1) begin
         @(posedge clock_in);
         #1;
      end
   endtask : finish

   task automatic judge(input row_s r);
      check("pass", r.ok, pass);
      check("fail", !r.ok, fail);
      check("pulses", r.pulses, pulses);
      check("reads", r.rd, rd_seen);
      check("violations", 0, viol);
   endtask : judge

   initial begin
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         kick(rows[i].need, rows[i].last);
         finish();
         judge(rows[i]);
      end
      // Starts arriving mid-run must not disturb the sequence
      kick(16'h0000, 16'h0003);
      repeat (100) @(posedge clock_in);
      start_prog <= 1'b1;
      start_id <= 1'b1;
      @(posedge clock_in);
      start_prog <= 1'b0;
      start_id <= 1'b0;
      finish();
      judge(rows[0]);
      check("mfr idle", 0, mfr_code);
      @(posedge clock_in);
      start_id <= 1'b1;
      @(posedge clock_in);
      start_id <= 1'b0;
      finish();
      check("mfr", MFR, mfr_code);
      check("dev", DEVC, dev_code);
      kick(16'h0000, 16'h0003);
      repeat (200) @(posedge clock_in);
      rst_n_in <= 1'b0;
      #1;
      check("ce_n reset", 1, ce_n);
      check("supply reset", SUP_OFF, supply);
      check("busy reset", 0, busy);
      @(posedge clock_in);
      rst_n_in <= 1'b1;
      kick(16'h0000, 16'h0003);
      finish();
      judge(rows[0]);
      summarize();
   end
endmodule : tb_top
